// *** inc/interval_timer_pkg.sv ***
/*
 * constants, register indices and carrier types of the three channel interval timer.
 * assumes a 32-bit axi4-lite register bus with one aligned word per register.
 */
`default_nettype none
package interval_timer_pkg;
    localparam int NUM_CTR = 3;
    localparam int AXI_ADDR_W = 10;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTR0 = 8'h18;
    localparam logic [7:0] IDX_CTR1 = 8'h1a;
    localparam logic [7:0] IDX_CTR2 = 8'h1c;
    localparam logic [7:0] IDX_CTRL = 8'h1e;
    localparam logic [1:0] SEL_READBACK = 2'h3;
    localparam logic [1:0] ACC_LATCH = 2'h0;
    localparam logic [1:0] ACC_LSB = 2'h1;
    localparam logic [1:0] ACC_MSB = 2'h2;
    localparam logic [1:0] ACC_PAIR = 2'h3;
    localparam logic [1:0] STEP_ONE = 2'h1;
    localparam logic [1:0] STEP_TWO = 2'h2;
    localparam logic [1:0] STEP_THREE = 2'h3;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam logic [15:0] COUNT_TWO = 16'h0002;
    localparam logic [15:0] BCD_TOP = 16'h9999;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {MODE0, MODE1, MODE2, MODE3, MODE4, MODE5} op_mode_t;

    typedef struct packed {
        logic target_select_hi;
        logic target_select_lo;
        logic byte_access_hi;
        logic byte_access_lo;
        logic op_mode_bit2;
        logic op_mode_bit1;
        logic op_mode_bit0;
        logic bcd_select;
    } ctrl_word_t;

    typedef struct packed {
        logic [1:0] marker;
        logic latch_count_n;
        logic latch_status_n;
        logic readback_pick_third;
        logic readback_pick_second;
        logic readback_pick_first;
        logic spare;
    } readback_t;

    typedef struct packed {
        logic out_level;
        logic null_count;
        logic [1:0] access;
        logic [2:0] mode;
        logic bcd;
    } status_t;

    // x10 and x11 fold onto modes 2 and 3
    function automatic op_mode_t to_mode(input ctrl_word_t c);
        if (c.op_mode_bit1) begin
            return op_mode_t'({1'b0, c.op_mode_bit1, c.op_mode_bit0});
        end
        return op_mode_t'({c.op_mode_bit2, c.op_mode_bit1, c.op_mode_bit0});
    endfunction : to_mode
endpackage : interval_timer_pkg
`default_nettype wire

// *** rtl/interval_timer.sv ***
/*
 * three channel 16-bit interval timer behind an axi4-lite slave.
 * assumes counter clock and gate pins are synchronous to aclk; counters step on a
 * falling edge of their own clock pin as seen at aclk.
 */
// Summary of operation
// - binary counts to 65535, decimal to 9999
// - both select bits set means read-back command
// - read-back count latch equals per-counter latches
// - status byte: output, null count, programming
// - latched status is returned by next read
// - mode 0: low, high at terminal count
// - mode 0: first byte halts, second restarts
// - mode 1: gate edge starts one-shot low pulse
// - mode 1: new count waits; gate edge retriggers
// - mode 2: one-clock low pulse each period
// - mode 2: gate low forces high, edge restarts
// - mode 3 even: step two, toggle, reload
// - mode 3 odd: first step one or three
// - mode 4: load starts, one-clock low strobe
// - mode 4: reload next clock, gate low pauses
// - mode 5: gate edge starts, strobe, retriggers
// - control and count writes interleave freely
// - latch command holds count without disturbing
// - select codes pick counters or read-back
// - access codes: latch, low, high, pair
// - mode codes and decimal select bit
`timescale 1ns/1ps
`default_nettype none
module interval_timer
    import interval_timer_pkg::*;
(
    input wire logic aclk, // 25 mhz bus clock
    input wire logic aresetn, // synchronous reset
    input wire logic [interval_timer_pkg::AXI_ADDR_W-1:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // byte enables
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [interval_timer_pkg::AXI_ADDR_W-1:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    input wire logic [interval_timer_pkg::NUM_CTR-1:0] ctr_clk, // counter clock pins
    input wire logic [interval_timer_pkg::NUM_CTR-1:0] ctr_gate, // counter gate pins
    output logic [interval_timer_pkg::NUM_CTR-1:0] ctr_out // counter outputs
);
    import interval_timer_pkg::*;

    // ********************************************************************
    // arithmetic
    // ********************************************************************
    function automatic logic [15:0] bcd_dec(input logic [15:0] v);
        logic [15:0] r;
        logic borrow;
        r = v;
        borrow = 1'b1;
        for (int d = 0; d < 4; d++) begin
            if (borrow) begin
                if (r[d*4+:4] == 4'h0) begin
                    r[d*4+:4] = 4'h9;
                end else begin
                    r[d*4+:4] = r[d*4+:4] - 4'h1;
                    borrow = 1'b0;
                end
            end
        end
        return r;
    endfunction : bcd_dec

    function automatic logic [15:0] count_down(input logic [15:0] v, input logic [1:0] step, input logic bcd);
        logic [15:0] r;
        r = v;
        for (int k = 0; k < 3; k++) begin
            if (k < int'(step)) begin
                r = bcd ? bcd_dec(r) : r - COUNT_ONE;
            end
        end
        return r;
    endfunction : count_down

    function automatic logic [7:0] ctr_idx(input int i);
        return IDX_CTR0 + 8'(2 * i);
    endfunction : ctr_idx

    // ********************************************************************
    // axi4-lite handshakes
    // ********************************************************************
    logic [AXI_ADDR_W-1:0] awaddr_q;
    logic [7:0] wbyte_q;
    logic wstrb0_q;
    logic wr_fire;
    logic rd_fire;
    logic [7:0] aw_idx;
    logic [7:0] ar_idx;
    logic [7:0] rd_byte;
    logic rd_mapped;

    assign wr_fire = !awready && !wready && !bvalid;
    assign rd_fire = arvalid && arready;
    assign aw_idx = awaddr_q[9:2];
    assign ar_idx = araddr[9:2];

    // address and data are taken in either order; the write acts once both are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            awaddr_q <= '0;
            wbyte_q <= 8'h00;
            wstrb0_q <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                awaddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                wbyte_q <= wdata[7:0];
                wstrb0_q <= wstrb[0];
            end
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp <= (aw_idx == IDX_CTRL || aw_idx == IDX_CTR0 || aw_idx == IDX_CTR1 || aw_idx == IDX_CTR2)
                    ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else begin
            if (rd_fire) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= {24'h00_0000, rd_byte};
                rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ********************************************************************
    // command decode
    // ********************************************************************
    ctrl_word_t cw;
    readback_t rb;
    logic wr_ctrl;
    logic [NUM_CTR-1:0] dw, dr, cw_mode, cw_latch, rb_cnt, rb_sta;
    logic [NUM_CTR-1:0] rb_pick;

    assign cw = ctrl_word_t'(wbyte_q);
    assign rb = readback_t'(wbyte_q);
    assign rb_pick = {rb.readback_pick_third, rb.readback_pick_second, rb.readback_pick_first};
    assign wr_ctrl = wr_fire && wstrb0_q && aw_idx == IDX_CTRL;

    always_comb begin
        for (int i = 0; i < NUM_CTR; i++) begin
            dw[i] = wr_fire && wstrb0_q && aw_idx == ctr_idx(i);
            dr[i] = rd_fire && ar_idx == ctr_idx(i);
            cw_mode[i] = wr_ctrl && {cw.target_select_hi, cw.target_select_lo} == 2'(i)
                && {cw.byte_access_hi, cw.byte_access_lo} != ACC_LATCH;
            cw_latch[i] = wr_ctrl && {cw.target_select_hi, cw.target_select_lo} == 2'(i)
                && {cw.byte_access_hi, cw.byte_access_lo} == ACC_LATCH;
            rb_cnt[i] = wr_ctrl && rb.marker == SEL_READBACK && !rb.latch_count_n
                && rb_pick[i];
            rb_sta[i] = wr_ctrl && rb.marker == SEL_READBACK && !rb.latch_status_n
                && rb_pick[i];
        end
    end

    // ********************************************************************
    // counters
    // ********************************************************************
    op_mode_t mode [NUM_CTR];
    logic [1:0] rw [NUM_CTR];
    logic [NUM_CTR-1:0] bcd, wptr, rptr, latched, st_latched, nul, load_pend, running, armed, halt, fresh, trig;
    logic [NUM_CTR-1:0] clk_prev, gate_prev, tick, gate_rise;
    logic [15:0] cr [NUM_CTR];
    logic [15:0] ce [NUM_CTR];
    logic [15:0] ol [NUM_CTR];
    status_t st [NUM_CTR];
    logic [1:0] step3 [NUM_CTR];

    assign tick = clk_prev & ~ctr_clk;
    assign gate_rise = ctr_gate & ~gate_prev;

    always_comb begin
        for (int i = 0; i < NUM_CTR; i++) begin
            step3[i] = (fresh[i] && cr[i][0]) ? (ctr_out[i] ? STEP_ONE : STEP_THREE) : STEP_TWO;
        end
    end

    // a count of zero stands for the full range, as the down-counter wraps through it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_CTR; i++) begin
                mode[i] <= MODE0;
                rw[i] <= ACC_LSB;
                cr[i] <= COUNT_RESET;
                ce[i] <= COUNT_RESET;
                ol[i] <= COUNT_RESET;
                st[i] <= '0;
            end
            {bcd, wptr, rptr, latched, st_latched, nul, load_pend} <= '0;
            {running, armed, halt, fresh, trig, clk_prev} <= '0;
            // gates idle high; a low reset value would fake a rising edge right after reset
            gate_prev <= '1;
            ctr_out <= '0;
        end else begin
            clk_prev <= ctr_clk;
            gate_prev <= ctr_gate;
            for (int i = 0; i < NUM_CTR; i++) begin
                if (tick[i]) begin
                    trig[i] <= 1'b0;
                    unique case (mode[i])
                        MODE0, MODE4: begin
                            if (load_pend[i]) begin
                                ce[i] <= cr[i];
                                {load_pend[i], nul[i]} <= 2'b00;
                                {running[i], armed[i]} <= 2'b11;
                                ctr_out[i] <= (mode[i] == MODE4);
                            end else if (running[i] && !halt[i] && ctr_gate[i]) begin
                                ce[i] <= count_down(ce[i], STEP_ONE, bcd[i]);
                                if (mode[i] == MODE0) begin
                                    if (ce[i] == COUNT_ONE) ctr_out[i] <= 1'b1;
                                end else begin
                                    ctr_out[i] <= !(armed[i] && ce[i] == COUNT_ONE);
                                    if (ce[i] == COUNT_ONE) armed[i] <= 1'b0;
                                end
                            end else if (mode[i] == MODE4) begin
                                ctr_out[i] <= 1'b1;
                            end
                        end
                        MODE1, MODE5: begin
                            if (trig[i]) begin
                                ce[i] <= cr[i];
                                {load_pend[i], nul[i]} <= 2'b00;
                                {running[i], armed[i]} <= 2'b11;
                                ctr_out[i] <= (mode[i] == MODE5);
                            end else if (running[i]) begin
                                ce[i] <= count_down(ce[i], STEP_ONE, bcd[i]);
                                if (mode[i] == MODE1) begin
                                    if (ce[i] == COUNT_ONE) ctr_out[i] <= 1'b1;
                                end else begin
                                    ctr_out[i] <= !(armed[i] && ce[i] == COUNT_ONE);
                                    if (ce[i] == COUNT_ONE) armed[i] <= 1'b0;
                                end
                            end
                        end
                        MODE2, MODE3: begin
                            if (!ctr_gate[i]) begin
                                ctr_out[i] <= 1'b1;
                            end else if (trig[i] || (load_pend[i] && !running[i])) begin
                                ce[i] <= cr[i];
                                {load_pend[i], nul[i]} <= 2'b00;
                                {running[i], fresh[i]} <= 2'b11;
                                ctr_out[i] <= 1'b1;
                            end else if (running[i] && mode[i] == MODE2) begin
                                if (ce[i] == COUNT_TWO) ctr_out[i] <= 1'b0;
                                if (ce[i] == COUNT_ONE) begin
                                    ce[i] <= cr[i];
                                    ctr_out[i] <= 1'b1;
                                    {load_pend[i], nul[i]} <= 2'b00;
                                end else begin
                                    ce[i] <= count_down(ce[i], STEP_ONE, bcd[i]);
                                end
                            end else if (running[i]) begin
                                if (ce[i] != COUNT_RESET && ce[i] <= {14'h0000, step3[i]}) begin
                                    ctr_out[i] <= !ctr_out[i];
                                    ce[i] <= cr[i];
                                    fresh[i] <= 1'b1;
                                    {load_pend[i], nul[i]} <= 2'b00;
                                end else begin
                                    ce[i] <= count_down(ce[i], step3[i], bcd[i]);
                                    fresh[i] <= 1'b0;
                                end
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                if (gate_rise[i]) trig[i] <= 1'b1;
                if (dr[i]) begin
                    if (st_latched[i]) begin
                        st_latched[i] <= 1'b0;
                    end else if (rw[i] == ACC_PAIR) begin
                        rptr[i] <= !rptr[i];
                        if (rptr[i]) latched[i] <= 1'b0;
                    end else begin
                        latched[i] <= 1'b0;
                    end
                end
                if (dw[i]) begin
                    if (rw[i] == ACC_PAIR && !wptr[i]) begin
                        cr[i][7:0] <= wbyte_q;
                        wptr[i] <= 1'b1;
                        if (mode[i] == MODE0) halt[i] <= 1'b1;
                    end else begin
                        unique case (rw[i])
                            ACC_LSB: cr[i] <= {8'h00, wbyte_q};
                            ACC_MSB: cr[i] <= {wbyte_q, 8'h00};
                            default: cr[i][15:8] <= wbyte_q;
                        endcase
                        wptr[i] <= 1'b0;
                        {load_pend[i], nul[i], halt[i]} <= 3'b110;
                        if (mode[i] == MODE0) ctr_out[i] <= 1'b0;
                    end
                end
                if ((cw_latch[i] || rb_cnt[i]) && !latched[i]) begin
                    ol[i] <= ce[i];
                    latched[i] <= 1'b1;
                end
                if (rb_sta[i] && !st_latched[i]) begin
                    st[i] <= {ctr_out[i], nul[i], rw[i], 3'(mode[i]), bcd[i]};
                    st_latched[i] <= 1'b1;
                end
                if (cw_mode[i]) begin
                    mode[i] <= to_mode(cw);
                    rw[i] <= {cw.byte_access_hi, cw.byte_access_lo};
                    bcd[i] <= cw.bcd_select;
                    ctr_out[i] <= (to_mode(cw) != MODE0);
                    {running[i], armed[i], halt[i], load_pend[i], nul[i]} <= 5'b00001;
                    // a gate edge seen before programming must not fire the new mode
                    trig[i] <= 1'b0;
                    {wptr[i], rptr[i], latched[i], st_latched[i]} <= 4'b0000;
                end
            end
        end
    end

    // ********************************************************************
    // read data select
    // ********************************************************************
    always_comb begin
        logic [15:0] val;
        val = COUNT_RESET;
        rd_byte = 8'h00;
        rd_mapped = (ar_idx == IDX_CTRL);
        for (int i = 0; i < NUM_CTR; i++) begin
            if (ar_idx == ctr_idx(i)) begin
                rd_mapped = 1'b1;
                val = latched[i] ? ol[i] : ce[i];
                if (st_latched[i]) begin
                    rd_byte = st[i];
                end else if (rw[i] == ACC_MSB || (rw[i] == ACC_PAIR && rptr[i])) begin
                    rd_byte = val[15:8];
                end else begin
                    rd_byte = val[7:0];
                end
            end
        end
    end

    // ********************************************************************
    // checks
    // ********************************************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_mode0_low;
        cw_mode[0] && to_mode(cw) == MODE0 |=> !ctr_out[0];
    endproperty
    a_mode0_low: assert property (p_mode0_low) else $error("mode 0 output not low");

    property p_latch_cmd;
        cw_latch[0] && !latched[0] |=> latched[0] && ol[0] == $past(ce[0]);
    endproperty
    a_latch_cmd: assert property (p_latch_cmd) else $error("latch missed count");

    property p_readback_cnt;
        rb_cnt[0] && rb_cnt[1] && !latched[0] && !latched[1] |=> latched[0] && latched[1];
    endproperty
    a_readback_cnt: assert property (p_readback_cnt) else $error("read-back latch missed");

    property p_status_bits;
        rb_sta[0] && !st_latched[0] |=> st_latched[0] && st[0].out_level == $past(ctr_out[0])
            && st[0].bcd == $past(bcd[0]) && st[0].access == $past(rw[0]);
    endproperty
    a_status_bits: assert property (p_status_bits) else $error("status byte wrong");

    property p_status_read;
        st_latched[0] && rd_fire && ar_idx == IDX_CTR0 |=> rvalid && rdata[7:0] == $past(st[0]);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status not returned");

    property p_pair_ptr;
        dw[0] && rw[0] == ACC_PAIR && !wptr[0] && !cw_mode[0] |=> wptr[0] ##1 (wptr[0] || $past(dw[0] || cw_mode[0]));
    endproperty
    a_pair_ptr: assert property (p_pair_ptr) else $error("byte pointer not toggled");

    property p_mode4_strobe;
        mode[0] == MODE4 && tick[0] && running[0] && armed[0] && ce[0] == COUNT_ONE && ctr_gate[0]
            && !load_pend[0] && !halt[0] && !cw_mode[0] |=> !ctr_out[0];
    endproperty
    a_mode4_strobe: assert property (p_mode4_strobe) else $error("mode 4 strobe missing");

    property p_bcd_wrap;
        bcd[0] && mode[0] == MODE0 && tick[0] && running[0] && !halt[0] && ctr_gate[0] && !load_pend[0]
            && ce[0] == COUNT_RESET && !cw_mode[0] |=> ce[0] == BCD_TOP;
    endproperty
    a_bcd_wrap: assert property (p_bcd_wrap) else $error("decimal wrap wrong");

    property p_mode2_pulse;
        mode[0] == MODE2 && tick[0] && ctr_gate[0] && running[0] && !trig[0] && ce[0] == COUNT_TWO
            && !cw_mode[0] |=> !ctr_out[0];
    endproperty
    a_mode2_pulse: assert property (p_mode2_pulse) else $error("mode 2 pulse missing");
endmodule : interval_timer
`default_nettype wire

// *** test/tb.sv ***
/* self-checking bench of the interval timer over axi4-lite.
   assumes the package and rtl/interval_timer.sv are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import interval_timer_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [AXI_ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [2:0] ctr_clk, ctr_gate, ctr_out;
    logic [7:0] rd;
    logic [15:0] n0, n1, v;
    int num_errors = 0, checks = 0, cycles = 0, lows = 0, highs = 0;
    interval_timer uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .ctr_clk, .ctr_gate, .ctr_out);
    initial begin
        aclk = 0;
        forever #20 aclk = ~aclk;
    end
    // ****************
    // bench tasks
    // ****************
    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= {idx, 2'h0}; wdata <= {24'h0, d}; wstrb <= 4'hf;
        awvalid <= 1; wvalid <= 1; bready <= 1;
        // the requests only land at the end of this step, so the first test waits an edge
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid && bready) begin bready <= 0; resp = bresp; end
        end while (awvalid || wvalid || bready);
    endtask : wr
    task automatic rdr(input logic [7:0] idx);
        @(posedge aclk);
        araddr <= {idx, 2'h0}; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid && rready) begin rready <= 0; resp = rresp; rd = rdata[7:0]; end
        end while (arvalid || rready);
    endtask : rdr
    task automatic rd16(input logic [7:0] idx);
        rdr(idx); v[7:0] = rd;
        rdr(idx); v[15:8] = rd;
    endtask : rd16
    // one tick is a high then low sample of the counter clock; two edges let ctr_out settle
    task automatic tick(input logic [2:0] m, input int n);
        repeat (n) begin
            @(posedge aclk) ctr_clk <= m;
            @(posedge aclk) ctr_clk <= 3'h0;
        end
        repeat (2) @(posedge aclk);
    endtask : tick
    // one low sample on gate 0, then high again; the rise is seen at the following edge
    task automatic gate_pulse;
        @(posedge aclk) ctr_gate <= 3'h6;
        @(posedge aclk) ctr_gate <= 3'h7;
    endtask : gate_pulse
    function automatic logic [15:0] stat(input logic o, input logic nc, input logic [7:0] c);
        return {8'h0, o, nc, c[5:0]};
    endfunction : stat
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb, ctr_clk} = '0;
        ctr_gate = 3'h7; aresetn = 0;
        n0 = 16'($urandom(36374));
        n0 = 16'(20 + $urandom_range(200));
        n1 = 16'(20 + $urandom_range(200));
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        rdr(8'h05); chk({14'h0, resp}, {14'h0, RESP_SLVERR});
        wr(8'h05, 8'h30); chk({14'h0, resp}, {14'h0, RESP_SLVERR});
        wr(IDX_CTRL, 8'h30); chk({15'h0, ctr_out[0]}, 16'h0);
        wr(IDX_CTRL, 8'h70);
        wr(IDX_CTRL, 8'he2); rdr(IDX_CTR0); chk({8'h0, rd}, stat(0, 1, 8'h30));
        wr(IDX_CTR0, n0[7:0]); wr(IDX_CTR1, n1[7:0]); wr(IDX_CTR0, n0[15:8]); wr(IDX_CTR1, n1[15:8]);
        tick(3'h3, 11);
        wr(IDX_CTRL, 8'hd6); tick(3'h3, 3);
        rd16(IDX_CTR0); chk(v, n0 - 16'd10);
        rd16(IDX_CTR1); chk(v, n1 - 16'd10);
        chk({15'h0, ctr_out[1]}, 16'h0);
        wr(IDX_CTRL, 8'h00); tick(3'h1, 2);
        rd16(IDX_CTR0); chk(v, n0 - 16'd13);
        tick(3'h1, int'(n0) - 16); chk({15'h0, ctr_out[0]}, 16'h0);
        tick(3'h1, 1); chk({15'h0, ctr_out[0]}, 16'h1);
        wr(IDX_CTRL, 8'he2); rdr(IDX_CTR0); chk({8'h0, rd}, stat(1, 0, 8'h30));
        wr(IDX_CTRL, 8'h94); chk({15'h0, ctr_out[2]}, 16'h1);
        wr(IDX_CTR2, 8'h04); tick(3'h4, 1);
        repeat (8) begin
            tick(3'h4, 1);
            lows += int'(ctr_out[2] === 1'b0);
        end
        chk(16'(lows), 16'h2);
        wr(IDX_CTRL, 8'h18); chk({15'h0, ctr_out[0]}, 16'h1);
        wr(IDX_CTR0, 8'h03); tick(3'h1, 1);
        @(posedge aclk) ctr_gate <= 3'h6;
        tick(3'h1, 3); chk({15'h0, ctr_out[0]}, 16'h1);
        @(posedge aclk) ctr_gate <= 3'h7;
        tick(3'h1, 2); chk({15'h0, ctr_out[0]}, 16'h1);
        tick(3'h1, 1); chk({15'h0, ctr_out[0]}, 16'h0);
        tick(3'h1, 1); chk({15'h0, ctr_out[0]}, 16'h1);
        wr(IDX_CTRL, 8'h14); wr(IDX_CTR0, 8'h03); tick(3'h1, 3); chk({15'h0, ctr_out[0]}, 16'h0);
        @(posedge aclk) ctr_gate <= 3'h6;
        tick(3'h1, 1); chk({15'h0, ctr_out[0]}, 16'h1);
        @(posedge aclk) ctr_gate <= 3'h7;
        tick(3'h1, 2); chk({15'h0, ctr_out[0]}, 16'h1);
        tick(3'h1, 1); chk({15'h0, ctr_out[0]}, 16'h0);
        wr(IDX_CTRL, 8'h12); wr(IDX_CTR0, 8'h03); tick(3'h1, 2); chk({15'h0, ctr_out[0]}, 16'h1);
        gate_pulse(); tick(3'h1, 2); chk({15'h0, ctr_out[0]}, 16'h0);
        gate_pulse(); tick(3'h1, 3); chk({15'h0, ctr_out[0]}, 16'h0);
        tick(3'h1, 1); chk({15'h0, ctr_out[0]}, 16'h1);
        wr(IDX_CTRL, 8'h1a); wr(IDX_CTR0, 8'h02); gate_pulse();
        tick(3'h1, 2); chk({15'h0, ctr_out[0]}, 16'h1);
        tick(3'h1, 1); chk({15'h0, ctr_out[0]}, 16'h0);
        tick(3'h1, 1); chk({15'h0, ctr_out[0]}, 16'h1);
        // over two whole periods the output is high n counts for even n and n+1 for odd n
        for (int p = 0; p < 2; p++) begin
            wr(IDX_CTRL, 8'h16); n1 = 16'(4 + p + 2 * $urandom_range(10)); wr(IDX_CTR0, n1[7:0]); tick(3'h1, 1);
            highs = 0;
            repeat (2 * int'(n1)) begin
                tick(3'h1, 1);
                highs += int'(ctr_out[0] === 1'b1);
            end
            chk(16'(highs), n1 + {15'h0, n1[0]});
        end
        wr(IDX_CTRL, 8'h31); wr(IDX_CTR0, 8'h01); wr(IDX_CTR0, 8'h00); tick(3'h1, 3);
        rd16(IDX_CTR0); chk(v, 16'h9999);
        chk({15'h0, ctr_out[0]}, 16'h1);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
